// file: rtl/pif_irq_flags.sv
// peripheral interrupt request flags, enables and core interrupt gating
//
// Contract
// - enable-3 holds pwm 3/2/1 enables, bits 6:4
// - all enables and flags reset to zero
// - request-1 bit 7: timer-1 gate pending
// - request-1 bit 6: conversion done pending
// - request-1 bit 5: serial rx, read-only
// - request-1 bit 4: serial tx pending
// - request-1 bit 1: timer-2 period match
// - request-1 bit 0: timer-1 overflow
// - flags set regardless of any enable
// - request-3 bits 6:4: pwm 3/2/1 pending
// - pwm flags mirror units, read-only
// - peripheral gate required to reach core
// - global gate clear blocks all interrupts; the code gates core_irq only, not the status irq
//
// Added by the designer: the strobed register port and the placing of the registers.
module pif_irq_flags
  import pif_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       evt_gate_acq,
  input  wire logic       evt_conv_done,
  input  wire logic       evt_serial_tx,
  input  wire logic       evt_t2_match,
  input  wire logic       evt_t1_ovf,
  input  wire logic       evt_comparator,
  input  wire logic       serial_rx_level,
  input  wire logic [2:0] pwm_pending,
  output logic            core_irq,
  output logic            irq
);

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] en1_ff, nxt_en1;
  logic [7:0] en2_ff, nxt_en2;
  logic [7:0] en3_ff, nxt_en3;
  logic [7:0] req1_ff, nxt_req1;
  logic [7:0] req2_ff, nxt_req2;
  logic [7:0] req3_ff, nxt_req3;
  logic [2:0] evt_ff, nxt_evt;
  logic [2:0] mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       core_irq_ff, nxt_core_irq;
  logic       irq_ff, nxt_irq;
  logic [7:0] req1_set;
  logic [7:0] req2_set;
  logic       periph_any;
  logic       addr_ok;

  // write helper: only implemented, software-writable bits take the new value
  function automatic logic [7:0] merge_wr(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [7:0] msk);
    merge_wr = (old & ~msk) | (wd & msk);
  endfunction

  function automatic logic in_map(input logic [3:0] a);
    in_map = (a <= ADDR_EVT_MASK);
  endfunction

  always_comb begin
    req1_set = RESET_VALUE;
    req1_set[BIT_GATE_ACQ]  = evt_gate_acq;
    req1_set[BIT_CONV_DONE] = evt_conv_done;
    req1_set[BIT_SERIAL_TX] = evt_serial_tx;
    req1_set[BIT_T2_MATCH]  = evt_t2_match;
    req1_set[BIT_T1_OVF]    = evt_t1_ovf;
    req2_set = RESET_VALUE;
    req2_set[BIT_COMPARATOR] = evt_comparator;
    addr_ok = in_map(reg_addr);
  end

  // register state: enables, event mask and control
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_en1  = en1_ff;
    nxt_en2  = en2_ff;
    nxt_en3  = en3_ff;
    nxt_mask = mask_ff;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_IRQ_CTRL: nxt_ctrl = reg_wdata & IMPL_MASK_CTRL;
        ADDR_EN_1:     nxt_en1  = reg_wdata & IMPL_MASK_1;
        ADDR_EN_2:     nxt_en2  = reg_wdata & IMPL_MASK_2;
        ADDR_EN_3:     nxt_en3  = reg_wdata & IMPL_MASK_3;
        ADDR_EVT_MASK: nxt_mask = reg_wdata[2:0];
        default:       nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  // request flags: events set, software may clear the writable ones
  always_comb begin
    // software-written flag bits: a write may clear, but a new event always wins
    nxt_req1 = req1_ff;
    if (reg_wr && reg_addr == ADDR_REQ_1) begin
      nxt_req1 = merge_wr(req1_ff, reg_wdata, SW_WRITE_MASK_1);
    end
    nxt_req1 = (nxt_req1 | req1_set) & IMPL_MASK_1;
    nxt_req1[BIT_SERIAL_RX] = serial_rx_level;
    nxt_req2 = req2_ff;
    if (reg_wr && reg_addr == ADDR_REQ_2) begin
      nxt_req2 = merge_wr(req2_ff, reg_wdata, IMPL_MASK_2);
    end
    nxt_req2 = (nxt_req2 | req2_set) & IMPL_MASK_2;
    nxt_req3 = RESET_VALUE;
    nxt_req3[BIT_PWM3] = pwm_pending[2];
    nxt_req3[BIT_PWM2] = pwm_pending[1];
    nxt_req3[BIT_PWM1] = pwm_pending[0];
  end

  // core gating: enabled flags need both the peripheral gate and the global gate
  always_comb begin
    periph_any = |(req1_ff & en1_ff) | |(req2_ff & en2_ff) | |(req3_ff & en3_ff);
    nxt_core_irq = periph_any && ctrl_ff[BIT_PERIPH_GATE]
                   && ctrl_ff[BIT_GLOBAL_GATE];
  end

  // sticky event status, cleared by a read of the status register; set wins over clear
  always_comb begin
    nxt_evt = evt_ff;
    if (reg_rd && reg_addr == ADDR_EVT_STATUS) begin
      nxt_evt = EVT_RESET;
    end
    if ((|req1_set) || evt_comparator) begin
      nxt_evt[EVT_FLAG_ANY] = 1'b1;
    end
    if (nxt_core_irq && !core_irq_ff) begin
      nxt_evt[EVT_CORE_IRQ] = 1'b1;
    end
    if ((reg_rd || reg_wr) && !addr_ok) begin
      nxt_evt[EVT_BAD_ADDR] = 1'b1;
    end
    nxt_irq = |(nxt_evt & mask_ff);
  end

  // read path: data stand one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = RESET_VALUE;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_IRQ_CTRL:   nxt_rdata = ctrl_ff;
        ADDR_EN_1:       nxt_rdata = en1_ff;
        ADDR_EN_2:       nxt_rdata = en2_ff;
        ADDR_EN_3:       nxt_rdata = en3_ff;
        ADDR_REQ_1:      nxt_rdata = req1_ff;
        ADDR_REQ_2:      nxt_rdata = req2_ff;
        ADDR_REQ_3:      nxt_rdata = req3_ff;
        ADDR_EVT_STATUS: nxt_rdata = {5'h00, evt_ff};
        ADDR_EVT_MASK:   nxt_rdata = {5'h00, mask_ff};
        default:         nxt_rdata = RESET_VALUE;
      endcase
    end
  end

  // enables, gates and event mask
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_ff <= RESET_VALUE;
      en1_ff  <= RESET_VALUE;
      en2_ff  <= RESET_VALUE;
      en3_ff  <= RESET_VALUE;
      mask_ff <= EVT_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      en1_ff  <= nxt_en1;
      en2_ff  <= nxt_en2;
      en3_ff  <= nxt_en3;
      mask_ff <= nxt_mask;
    end
  end

  // request flags
  always_ff @(posedge clock) begin
    if (rst) begin
      req1_ff <= RESET_VALUE;
      req2_ff <= RESET_VALUE;
      req3_ff <= RESET_VALUE;
    end else begin
      req1_ff <= nxt_req1;
      req2_ff <= nxt_req2;
      req3_ff <= nxt_req3;
    end
  end

  // core interrupt level, one cycle behind the gated flags
  always_ff @(posedge clock) begin
    if (rst) begin
      core_irq_ff <= 1'b0;
    end else begin
      core_irq_ff <= nxt_core_irq;
    end
  end

  // sticky status and its interrupt
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_ff <= EVT_RESET;
      irq_ff <= 1'b0;
    end else begin
      evt_ff <= nxt_evt;
      irq_ff <= nxt_irq;
    end
  end

  // read data register: zero outside the answer cycle keeps a shared bus quiet
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= RESET_VALUE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign core_irq  = core_irq_ff;
  assign irq       = irq_ff;

  // no flag is ever enabled by hardware; software is expected to clear first

  chk_unimpl_zero: assert property (@(posedge clock) disable iff (rst)
    ((req1_ff & ~IMPL_MASK_1) == 8'h00) && ((en3_ff & ~IMPL_MASK_3) == 8'h00)
    && ((req3_ff & ~IMPL_MASK_3) == 8'h00) && ((req2_ff & ~IMPL_MASK_2) == 8'h00))
    else $error("unimplemented bit set");

  chk_reset_clear: assert property (@(posedge clock)
    rst |=> (en1_ff == 8'h00 && en2_ff == 8'h00 && en3_ff == 8'h00 && ctrl_ff == 8'h00
    && req1_ff == 8'h00 && req2_ff == 8'h00 && req3_ff == 8'h00
    && reg_rdata == 8'h00 && !core_irq && !irq))
    else $error("state not zero after reset");

  chk_event_sets: assert property (@(posedge clock) disable iff (rst)
    evt_t1_ovf |=> req1_ff[BIT_T1_OVF])
    else $error("overflow event lost");

  chk_gate_acq: assert property (@(posedge clock) disable iff (rst)
    evt_gate_acq |=> req1_ff[BIT_GATE_ACQ])
    else $error("gate event lost");

  chk_set_wins: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_REQ_2 && evt_comparator) |=> req2_ff[BIT_COMPARATOR])
    else $error("clear beat set");

  chk_wr_clear: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_REQ_2 && !reg_wdata[BIT_COMPARATOR] && !evt_comparator)
    |=> !req2_ff[BIT_COMPARATOR])
    else $error("comparator flag not cleared");

  chk_rx_follows: assert property (@(posedge clock) disable iff (rst)
    ##1 req1_ff[BIT_SERIAL_RX] == $past(serial_rx_level))
    else $error("rx flag not following receiver");

  chk_pwm_mirror: assert property (@(posedge clock) disable iff (rst)
    ##1 req3_ff[6:4] == $past(pwm_pending))
    else $error("pwm mirror wrong");

  chk_gate_block: assert property (@(posedge clock) disable iff (rst)
    !ctrl_ff[BIT_PERIPH_GATE] |=> !core_irq_ff)
    else $error("core irq without peripheral gate");

  chk_global_hold: assert property (@(posedge clock) disable iff (rst)
    (!ctrl_ff[BIT_GLOBAL_GATE] ##1 (ctrl_ff[BIT_GLOBAL_GATE] && ctrl_ff[BIT_PERIPH_GATE]
    && periph_any)) |=> core_irq_ff)
    else $error("pending irq not serviced");

  chk_pwm_enable: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_EN_3) |=> en3_ff[BIT_PWM3] == $past(reg_wdata[BIT_PWM3]))
    else $error("pwm3 enable not stored");

  chk_pwm2_enable: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_EN_3)
    |=> (en3_ff[BIT_PWM2] == $past(reg_wdata[BIT_PWM2])))
    else $error("pwm2 enable not stored");

  chk_pwm1_enable: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_EN_3)
    |=> (en3_ff[BIT_PWM1] == $past(reg_wdata[BIT_PWM1])))
    else $error("pwm1 enable not stored");

  chk_en1_store: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_EN_1)
    |=> (en1_ff == ($past(reg_wdata) & IMPL_MASK_1)))
    else $error("enable 1 write wrong");

  chk_en2_store: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_EN_2)
    |=> (en2_ff == ($past(reg_wdata) & IMPL_MASK_2)))
    else $error("enable 2 write wrong");

  chk_ctrl_store: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_IRQ_CTRL)
    |=> (ctrl_ff == ($past(reg_wdata) & IMPL_MASK_CTRL)))
    else $error("control write wrong");

  chk_conv_sets: assert property (@(posedge clock) disable iff (rst)
    evt_conv_done
    |=> req1_ff[BIT_CONV_DONE])
    else $error("conversion event lost");

  chk_tx_sets: assert property (@(posedge clock) disable iff (rst)
    evt_serial_tx
    |=> req1_ff[BIT_SERIAL_TX])
    else $error("transmit event lost");

  chk_match_sets: assert property (@(posedge clock) disable iff (rst)
    evt_t2_match
    |=> req1_ff[BIT_T2_MATCH])
    else $error("period match event lost");

  chk_cmp_sets: assert property (@(posedge clock) disable iff (rst)
    evt_comparator
    |=> req2_ff[BIT_COMPARATOR])
    else $error("comparator event lost");

  chk_rx_readonly: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_REQ_1)
    |=> (req1_ff[BIT_SERIAL_RX] == $past(serial_rx_level)))
    else $error("rx flag took a write");

  chk_req3_readonly: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_REQ_3)
    |=> (req3_ff == {1'b0, $past(pwm_pending), 4'h0}))
    else $error("pwm flags took a write");

  chk_flag_holds: assert property (@(posedge clock) disable iff (rst)
    (!(reg_wr && reg_addr == ADDR_REQ_2) && !evt_comparator)
    |=> (req2_ff == $past(req2_ff)))
    else $error("comparator flag moved on its own");

  chk_req1_clear: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_REQ_1 && reg_wdata == 8'h00
    && !evt_gate_acq && !evt_conv_done && !evt_serial_tx && !evt_t2_match && !evt_t1_ovf)
    |=> ((req1_ff & SW_WRITE_MASK_1) == 8'h00))
    else $error("request 1 not cleared");

  chk_req2_write: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_REQ_2 && reg_wdata[BIT_COMPARATOR])
    |=> req2_ff[BIT_COMPARATOR])
    else $error("comparator flag write lost");

  chk_core_needs_en: assert property (@(posedge clock) disable iff (rst)
    !periph_any
    |=> !core_irq_ff)
    else $error("core irq without enabled flag");

  chk_global_block: assert property (@(posedge clock) disable iff (rst)
    !ctrl_ff[BIT_GLOBAL_GATE]
    |=> !core_irq_ff)
    else $error("core irq without global gate");

  chk_core_raise: assert property (@(posedge clock) disable iff (rst)
    (periph_any && ctrl_ff[BIT_PERIPH_GATE] && ctrl_ff[BIT_GLOBAL_GATE])
    |=> core_irq_ff)
    else $error("gated flag did not reach core");

  chk_status_sticky: assert property (@(posedge clock) disable iff (rst)
    (evt_ff[EVT_BAD_ADDR] && !(reg_rd && reg_addr == ADDR_EVT_STATUS))
    |=> evt_ff[EVT_BAD_ADDR])
    else $error("status bit lost without read");

  chk_status_clear: assert property (@(posedge clock) disable iff (rst)
    (reg_rd && reg_addr == ADDR_EVT_STATUS)
    |=> !evt_ff[EVT_BAD_ADDR])
    else $error("status bit not cleared by read");

  chk_unmapped_flag: assert property (@(posedge clock) disable iff (rst)
    ((reg_rd || reg_wr) && reg_addr > ADDR_EVT_MASK)
    |=> evt_ff[EVT_BAD_ADDR])
    else $error("unmapped access not flagged");

  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    ##1
    (irq_ff == |(evt_ff & $past(mask_ff))))
    else $error("irq level does not match status");

  chk_rdata_idle: assert property (@(posedge clock) disable iff (rst)
    !reg_rd
    |=> (reg_rdata == 8'h00))
    else $error("read data outside answer cycle");

endmodule

// file: rtl/pif_pkg.sv
// package: register map, field positions and reset values of the peripheral irq flag/enable block
package pif_pkg;
  localparam logic [3:0] ADDR_IRQ_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_EN_1        = 4'h1;
  localparam logic [3:0] ADDR_EN_2        = 4'h2;
  localparam logic [3:0] ADDR_EN_3        = 4'h3;
  localparam logic [3:0] ADDR_REQ_1       = 4'h4;
  localparam logic [3:0] ADDR_REQ_2       = 4'h5;
  localparam logic [3:0] ADDR_REQ_3       = 4'h6;
  localparam logic [3:0] ADDR_EVT_STATUS  = 4'h7;
  localparam logic [3:0] ADDR_EVT_MASK    = 4'h8;
  localparam logic [7:0] IMPL_MASK_1      = 8'hF3;
  localparam logic [7:0] IMPL_MASK_2      = 8'h20;
  localparam logic [7:0] IMPL_MASK_3      = 8'h70;
  localparam logic [7:0] IMPL_MASK_CTRL   = 8'hC0;
  localparam logic [7:0] SW_WRITE_MASK_1  = 8'hD3;
  localparam int         BIT_GLOBAL_GATE  = 7;
  localparam int         BIT_PERIPH_GATE  = 6;
  localparam int         BIT_GATE_ACQ     = 7;
  localparam int         BIT_CONV_DONE    = 6;
  localparam int         BIT_SERIAL_RX    = 5;
  localparam int         BIT_SERIAL_TX    = 4;
  localparam int         BIT_T2_MATCH     = 1;
  localparam int         BIT_T1_OVF       = 0;
  localparam int         BIT_COMPARATOR   = 5;
  localparam int         BIT_PWM3         = 6;
  localparam int         BIT_PWM2         = 5;
  localparam int         BIT_PWM1         = 4;
  localparam logic [7:0] RESET_VALUE      = 8'h00;
  localparam logic [2:0] EVT_RESET        = 3'h0;
  localparam int         EVT_FLAG_ANY     = 0;
  localparam int         EVT_CORE_IRQ     = 1;
  localparam int         EVT_BAD_ADDR     = 2;
endpackage

// file: tb/pif_periph_model.sv
// partner model: peripheral event sources driving one-cycle event pulses
module pif_periph_model (
  input  wire logic       clock,
  input  wire logic [5:0] fire,
  output logic      [5:0] evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // a pulse leaves the unit whatever the enables hold
  always_ff @(posedge clock) begin
    evt <= fire;
  end
endmodule

// file: tb/test_peripheral_irq_flags_enables.sv
// testbench: register access, event flags, core gating and status interrupt
module test_peripheral_irq_flags_enables
  import pif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       serial_rx_level = 1'b0;
  logic [2:0] pwm_pending = 3'h0;
  logic [5:0] fire = 6'h00;
  logic [5:0] evt;
  logic       core_irq;
  logic       irq;
  int         n_errors = 0;
  int         samples_checked = 0;
  int         seed = 32'h12654360;
  logic [7:0] d;
  logic [5:0] v;
  logic [7:0] imask [4] = '{IMPL_MASK_CTRL, IMPL_MASK_1, IMPL_MASK_2, IMPL_MASK_3};

  always #20 clock = ~clock;

  pif_periph_model pif_periph_model_i (.clock(clock), .fire(fire), .evt(evt));
  pif_irq_flags pif_irq_flags_i (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_gate_acq(evt[5]), .evt_conv_done(evt[4]),
    .evt_serial_tx(evt[3]), .evt_t2_match(evt[2]), .evt_t1_ovf(evt[1]), .evt_comparator(evt[0]),
    .serial_rx_level(serial_rx_level), .pwm_pending(pwm_pending), .core_irq(core_irq), .irq(irq));

  function automatic logic [7:0] exp_req1(input logic [5:0] e, input logic rx);
    return {e[5], e[4], rx, e[3], 2'b00, e[2], e[1]};
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask

  task automatic pulse(input logic [5:0] p);
    @(posedge clock);
    fire <= p;
    @(posedge clock);
    fire <= 6'h00;
    repeat (2) @(posedge clock);
  endtask

  // core_irq is registered two cycles behind its cause, so three is enough
  task automatic settle;
    repeat (3) @(negedge clock);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 9; a++) rdc(a[3:0], RESET_VALUE);
    for (int a = 0; a < 4; a++) begin
      d = $random(seed);
      wr(a[3:0], d);
      rdc(a[3:0], d & imask[a]);
      wr(a[3:0], 8'hFF);
      rdc(a[3:0], imask[a]);
      wr(a[3:0], 8'h00);
    end
    wr(4'hC, 8'hFF);
    rdc(4'hC, 8'h00);
    rdc(ADDR_EVT_STATUS, 8'h04);
    v = $random(seed);
    v[0] = 1'b0;
    pulse(v);
    rdc(ADDR_REQ_1, exp_req1(v, 1'b0));
    pulse(6'h3E);
    serial_rx_level <= 1'b1;
    rdc(ADDR_REQ_1, 8'hF3);
    wr(ADDR_REQ_1, 8'h00);
    rdc(ADDR_REQ_1, 8'h20);
    @(posedge clock);
    serial_rx_level <= 1'b0;
    wr(ADDR_REQ_1, 8'hFF);
    rdc(ADDR_REQ_1, 8'hD3);
    wr(ADDR_REQ_1, 8'h00);
    pulse(6'h01);
    rdc(ADDR_REQ_2, 8'h20);
    wr(ADDR_REQ_2, 8'hFF);
    rdc(ADDR_REQ_2, 8'h20);
    wr(ADDR_REQ_2, 8'hDF);
    rdc(ADDR_REQ_2, 8'h00);
    // event and clearing write land on the same edge
    @(posedge clock);
    fire <= 6'h01;
    @(posedge clock);
    fire <= 6'h00;
    reg_wr <= 1'b1;
    reg_addr <= ADDR_REQ_2;
    reg_wdata <= 8'h00;
    @(posedge clock);
    reg_wr <= 1'b0;
    rdc(ADDR_REQ_2, 8'h20);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      pwm_pending <= (k == 0) ? 3'h7 : 3'($random(seed));
      repeat (2) @(posedge clock);
      rdc(ADDR_REQ_3, {1'b0, pwm_pending, 4'h0});
      wr(ADDR_REQ_3, 8'h00);
      rdc(ADDR_REQ_3, {1'b0, pwm_pending, 4'h0});
    end
    @(posedge clock);
    pwm_pending <= 3'h0;
    wr(ADDR_REQ_2, 8'h00); // flag cleared before its enable is set
    wr(ADDR_EN_2, 8'h20);
    pulse(6'h01);
    wr(ADDR_IRQ_CTRL, 8'h40);
    settle();
    chk({7'h00, core_irq}, 8'h00);
    wr(ADDR_IRQ_CTRL, 8'h80);
    settle();
    chk({7'h00, core_irq}, 8'h00);
    wr(ADDR_IRQ_CTRL, 8'hC0);
    settle();
    chk({7'h00, core_irq}, 8'h01);
    wr(ADDR_REQ_2, 8'h00);
    settle();
    chk({7'h00, core_irq}, 8'h00);
    rdc(ADDR_EVT_STATUS, 8'h03);
    wr(ADDR_EVT_MASK, 8'h01);
    pulse(6'h02);
    @(negedge clock);
    chk({7'h00, irq}, 8'h01);
    rdc(ADDR_EVT_STATUS, 8'h01);
    settle();
    chk({7'h00, irq}, 8'h00);
    end_sim();
  end
endmodule
